// ### rtl/swdeh_defines.vh
// swdeh_defines.vh: offsets, fields, reset values and timing for the supervisor block
// assumes a 40 MHz pclk; every time is given in its own unit and turned into cycles here
`ifndef SWDEH_DEFINES_VH
`define SWDEH_DEFINES_VH

`define SWDEH_CLK_HZ        40000000
`define SWDEH_TMO_MS        280
`define SWDEH_TMO_CYC       (`SWDEH_TMO_MS * (`SWDEH_CLK_HZ / 1000))
`define SWDEH_HOLD_MS       200
`define SWDEH_HOLD_CYC      (`SWDEH_HOLD_MS * (`SWDEH_CLK_HZ / 1000))
`define SWDEH_PF_DLY_US     35
`define SWDEH_PF_DLY_CYC    (`SWDEH_PF_DLY_US * (`SWDEH_CLK_HZ / 1000000))

`define SWDEH_OFF_HOLD      12'h000
`define SWDEH_OFF_TMO       12'h004
`define SWDEH_OFF_STAT      12'h008

`define SWDEH_ST_RESET      0
`define SWDEH_ST_PFAIL      1
`define SWDEH_ST_REG_ON     2
`define SWDEH_ST_SHDN       3
`define SWDEH_ST_SLOW       4
`define SWDEH_ST_FAST       5
`define SWDEH_ST_WD_RUN     6

`define SWDEH_RP_USER       2'h0
`define SWDEH_RP_FIXED      2'h1
`define SWDEH_RP_FORCE      2'h2

`define SWDEH_SH_R8         3
`define SWDEH_SH_R16        4
`define SWDEH_SH_R64        6

`endif

// ### rtl/swdeh_sync.v
// swdeh_sync: two-flop synchroniser for a group of pin levels
// assumes every input is a slow level from outside the pclk domain
`timescale 1ns/1ps
module swdeh_sync #(
	parameter W = 1
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// the first stage feeds only the second
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end
		else
		begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule

// ### rtl/swdeh_keep_on.v
// swdeh_keep_on: turn-on / keep-on latch for the regulated output
// assumes both inputs are already synchronised to pclk
`timescale 1ns/1ps
module swdeh_keep_on (
	input  wire pclk,
	input  wire presetn,
	input  wire turn_on,
	input  wire keep_on_n,
	output reg  reg_on_ff,
	output reg  shutdown_ff
);
	wire nxt_reg_on;
	wire nxt_shutdown;

	// keep-on low holds a running output; releasing it drops the output
	assign nxt_reg_on   = turn_on | (reg_on_ff & ~keep_on_n);
	assign nxt_shutdown = ~turn_on & keep_on_n;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reg_on_ff   <= 1'b0;
			shutdown_ff <= 1'b1;
		end
		else
		begin
			reg_on_ff   <= nxt_reg_on;
			shutdown_ff <= nxt_shutdown;
		end
	end
endmodule

// ### rtl/swdeh_top.v
// swdeh_top: watchdog, reset generator, supply-fail flag and keep-on latch with APB registers
// assumes pins arrive asynchronously and the APB master runs on pclk
`timescale 1ns/1ps
`include "swdeh_defines.vh"
module swdeh_top #(
	parameter [31:0] TMO_CYC  = `SWDEH_TMO_CYC,
	parameter [31:0] HOLD_CYC = `SWDEH_HOLD_CYC,
	parameter        WINDOWED = 1
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        watchdog_toggle_input,
	input  wire        turn_on_input_one,
	input  wire        keep_on_input_n,
	input  wire        supply_monitor_input,
	input  wire        output_below_threshold,
	input  wire [1:0]  reset_period_pin,
	input  wire        watchdog_period_pin,
	input  wire        watchdog_disable_input_n,
	input  wire        window_select_bit_zero,
	input  wire        window_select_bit_one,
	output reg         reset_out_n,
	output wire        supply_fail_output_n,
	output wire        regulated_output_one,
	output wire        shutdown_mode
);
	localparam [31:0] PF_DLY = `SWDEH_PF_DLY_CYC;

	wire [10:0] pins_s;
	wire        wdi_s;
	wire        ton_s;
	wire        keepn_s;
	wire        pfi_s;
	wire        outlow_s;
	wire [1:0]  rpp_s;
	wire        wpp_s;
	wire        wddisn_s;
	wire        window_select_bit_zero_s;
	wire        window_select_bit_one_s;

	reg         wdi_prev_ff;
	reg  [31:0] wd_cnt_ff;
	reg  [31:0] hold_cnt_ff;
	reg  [31:0] hold_reg_ff;
	reg  [31:0] tmo_reg_ff;
	reg         slow_flag_ff;
	reg         fast_flag_ff;
	reg         fail_n_ff;
	reg  [31:0] pf_cnt_ff;

	wire        edge_seen;
	wire        wd_enabled;
	wire [31:0] hold_len;
	wire [31:0] slow_len;
	reg  [31:0] fast_len;
	wire        slow_fault;
	wire        fast_fault;
	wire        wd_fault;
	wire        force_low;
	wire        setup_ph;
	wire        access_ph;
	wire        wr_stat;
	reg  [31:0] rd_mux;
	reg         rd_err;

	// keep-on rides inverted so the cleared flops match its idle-high pin after reset
	swdeh_sync #(
		.W(11)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({watchdog_toggle_input, turn_on_input_one, ~keep_on_input_n,
		           supply_monitor_input, output_below_threshold, reset_period_pin,
		           watchdog_period_pin, watchdog_disable_input_n,
		           window_select_bit_zero, window_select_bit_one}),
		.q       (pins_s)
	);

	assign wdi_s    = pins_s[10];
	assign ton_s    = pins_s[9];
	assign keepn_s  = ~pins_s[8];
	assign pfi_s    = pins_s[7];
	assign outlow_s = pins_s[6];
	assign rpp_s    = pins_s[5:4];
	assign wpp_s    = pins_s[3];
	assign wddisn_s = pins_s[2];
	assign window_select_bit_zero_s   = pins_s[1];
	assign window_select_bit_one_s   = pins_s[0];

	swdeh_keep_on u_keep_on (
		.pclk        (pclk),
		.presetn     (presetn),
		.turn_on     (ton_s),
		.keep_on_n   (keepn_s),
		.reg_on_ff   (regulated_output_one),
		.shutdown_ff (shutdown_mode)
	);

	// either edge of the toggle input services the watchdog
	// the edge is seen two cycles late, a small slack against both windows
	assign edge_seen = wdi_s ^ wdi_prev_ff;

	// windowed parts disable by select bits, others by the disable pin
	assign wd_enabled = (WINDOWED != 0) ? !(window_select_bit_zero_s && !window_select_bit_one_s)
	                                    : wddisn_s;

	// strap picks fixed or software hold; timeout picked apart from it
	assign hold_len = (rpp_s == `SWDEH_RP_FIXED) ? HOLD_CYC : hold_reg_ff;
	assign slow_len = wpp_s ? TMO_CYC : tmo_reg_ff;

	// fast window is a fixed ratio of the slow one
	// select 01 is the off setting, so it gets no fast limit
	always @*
	begin
		case ({window_select_bit_one_s, window_select_bit_zero_s})
			2'b00:   fast_len = slow_len >> `SWDEH_SH_R8;
			2'b10:   fast_len = slow_len >> `SWDEH_SH_R16;
			2'b11:   fast_len = slow_len >> `SWDEH_SH_R64;
			default: fast_len = 32'h0000_0000;
		endcase
	end

	assign slow_fault = wd_enabled && !edge_seen && (wd_cnt_ff >= slow_len - 32'h0000_0001);
	assign fast_fault = (WINDOWED != 0) && wd_enabled && edge_seen
	                    && (wd_cnt_ff < fast_len);
	assign wd_fault   = slow_fault || fast_fault;
	// strap code 2 holds reset for good; a low output holds it too
	assign force_low  = (rpp_s == `SWDEH_RP_FORCE) || outlow_s;

	// watchdog counter and reset sequencer
	// the toggle level is tracked in every state so no stale edge outlives a reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdi_prev_ff <= 1'b0;
			wd_cnt_ff   <= 32'h0000_0000;
			hold_cnt_ff <= 32'h0000_0000;
			reset_out_n <= 1'b0;
		end
		else
		begin
			wdi_prev_ff <= wdi_s;
			if (force_low)
			begin
				reset_out_n <= 1'b0;
				hold_cnt_ff <= 32'h0000_0000;
				wd_cnt_ff   <= 32'h0000_0000;
			end
			else if (!reset_out_n)
			begin
				// toggle edges have no say here, so the hold is exact
				wd_cnt_ff <= 32'h0000_0000;
				if (hold_cnt_ff >= hold_len - 32'h0000_0001)
				begin
					reset_out_n <= 1'b1;
					hold_cnt_ff <= 32'h0000_0000;
				end
				else
				begin
					hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
				end
			end
			else if (wd_fault)
			begin
				reset_out_n <= 1'b0;
				hold_cnt_ff <= 32'h0000_0000;
				wd_cnt_ff   <= 32'h0000_0000;
			end
			else if (!wd_enabled || edge_seen)
			begin
				wd_cnt_ff <= 32'h0000_0000;
			end
			else
			begin
				wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
			end
		end
	end

	// supply-fail output follows the monitor once it has differed for the delay
	// a monitor blip shorter than the delay never reaches the pin
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fail_n_ff <= 1'b1;
			pf_cnt_ff <= 32'h0000_0000;
		end
		else if (fail_n_ff == pfi_s)
		begin
			pf_cnt_ff <= 32'h0000_0000;
		end
		else if (pf_cnt_ff >= PF_DLY - 32'h0000_0001)
		begin
			fail_n_ff <= pfi_s;
			pf_cnt_ff <= 32'h0000_0000;
		end
		else
		begin
			pf_cnt_ff <= pf_cnt_ff + 32'h0000_0001;
		end
	end

	// the pin is the flop itself, no gate after it
	assign supply_fail_output_n = fail_n_ff;

	// apb: answer prepared at setup, ready high in the access cycle
	// zero wait states; masters still wait on pready, so this may grow later
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable && pready;
	assign wr_stat   = access_ph && pwrite && !pslverr && (paddr == `SWDEH_OFF_STAT);

	always @*
	begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			`SWDEH_OFF_HOLD: rd_mux = hold_reg_ff;
			`SWDEH_OFF_TMO:  rd_mux = tmo_reg_ff;
			`SWDEH_OFF_STAT:
			begin
				rd_mux[`SWDEH_ST_RESET]  = !reset_out_n;
				rd_mux[`SWDEH_ST_PFAIL]  = !fail_n_ff;
				rd_mux[`SWDEH_ST_REG_ON] = regulated_output_one;
				rd_mux[`SWDEH_ST_SHDN]   = shutdown_mode;
				rd_mux[`SWDEH_ST_SLOW]   = slow_flag_ff;
				rd_mux[`SWDEH_ST_FAST]   = fast_flag_ff;
				rd_mux[`SWDEH_ST_WD_RUN] = wd_enabled && reset_out_n;
			end
			default: rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			hold_reg_ff  <= HOLD_CYC;
			tmo_reg_ff   <= TMO_CYC;
			slow_flag_ff <= 1'b0;
			fast_flag_ff <= 1'b0;
		end
		else
		begin
			pready <= setup_ph;
			if (setup_ph)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= rd_err;
			end
			else if (access_ph)
			begin
				prdata  <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
			// zero would stall the counters, so it is refused
			if (access_ph && pwrite && !pslverr && (pwdata != 32'h0000_0000))
			begin
				if (paddr == `SWDEH_OFF_HOLD)
					hold_reg_ff <= pwdata;
				if (paddr == `SWDEH_OFF_TMO)
					tmo_reg_ff <= pwdata;
			end
			// a fault in the clearing cycle wins over the clear
			slow_flag_ff <= (reset_out_n && !force_low && slow_fault)
			                || (slow_flag_ff && !(wr_stat && pwdata[`SWDEH_ST_SLOW]));
			fast_flag_ff <= (reset_out_n && !force_low && fast_fault)
			                || (fast_flag_ff && !(wr_stat && pwdata[`SWDEH_ST_FAST]));
		end
	end
endmodule

// ### tb/swdeh_props.sv
// swdeh_props: pin-level assertions on the supervisor block
// assumes a single pclk domain, bound into every swdeh_top
`timescale 1ns/1ps
module swdeh_props #(
	parameter [31:0] TMO_CYC  = 200,
	parameter [31:0] HOLD_CYC = 50
) (
	input wire       pclk,
	input wire       presetn,
	input wire       watchdog_toggle_input,
	input wire       turn_on_input_one,
	input wire       keep_on_input_n,
	input wire       supply_monitor_input,
	input wire       output_below_threshold,
	input wire [1:0] reset_period_pin,
	input wire       window_select_bit_zero,
	input wire       window_select_bit_one,
	input wire       reset_out_n,
	input wire       supply_fail_output_n,
	input wire       regulated_output_one,
	input wire       shutdown_mode
);
	reg [31:0] low_ff;
	reg [31:0] idle_ff;
	reg [31:0] mon_low_ff;
	reg        tog_ff;
	wire       wd_off = window_select_bit_zero && !window_select_bit_one;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// margin of 8 covers the input flops on both ends
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_ff  <= 32'h0000_0000;
			idle_ff <= 32'h0000_0000;
			tog_ff  <= 1'b0;
			mon_low_ff <= 32'h0000_0000;
		end
		else
		begin
			tog_ff  <= watchdog_toggle_input;
			mon_low_ff <= supply_monitor_input ? 32'h0000_0000 : mon_low_ff + 32'h0000_0001;
			low_ff  <= reset_out_n ? 32'h0000_0000 : low_ff + 32'h0000_0001;
			idle_ff <= (!reset_out_n || wd_off || tog_ff != watchdog_toggle_input) ?
				32'h0000_0000 : idle_ff + 32'h0000_0001;
		end
	end
	AST_WD_TMO: assert property (idle_ff < TMO_CYC + 8)
		else $error("no reset after timeout");
	AST_HOLD: assert property ($rose(reset_out_n) |-> low_ff >= HOLD_CYC)
		else $error("reset hold too short");
	AST_TURN_ON: assert property (turn_on_input_one [*4] |=> regulated_output_one)
		else $error("turn-on ignored");
	AST_KEEP: assert property ((!keep_on_input_n) [*4] ##0 regulated_output_one
		|=> regulated_output_one)
		else $error("keep-on lost");
	AST_OFF: assert property ((!turn_on_input_one && keep_on_input_n) [*4]
		|=> !regulated_output_one && shutdown_mode)
		else $error("no shutdown");
	AST_FORCE: assert property ((reset_period_pin == 2'h2) [*4] |=> !reset_out_n)
		else $error("forced reset missing");
	AST_BELOW: assert property (output_below_threshold [*4] |=> !reset_out_n)
		else $error("low output without reset");
	// 1400-cycle filter plus the input flops, counted rather than unrolled
	AST_PFAIL: assert property (mon_low_ff < 32'h0000_0582 || !supply_fail_output_n)
		else $error("supply fail missing");
endmodule

bind swdeh_top swdeh_props #(.TMO_CYC(TMO_CYC), .HOLD_CYC(HOLD_CYC)) u_swdeh_props (.*);

// ### tb/swdeh_host.sv
// swdeh_host: host that services the watchdog toggle
// assumes period in pclk cycles, 0 = host stopped
`timescale 1ns/1ps
module swdeh_host (
	input  wire        pclk,
	input  wire        reset_out_n,
	input  wire [15:0] period,
	input  wire        rude,
	output reg         toggle_ff
);
	reg [15:0] cnt_ff;
	initial
	begin
		cnt_ff    = 16'h0000;
		toggle_ff = 1'b0;
	end
	// a polite host sits in reset while reset is low; rude keeps toggling
	always @(posedge pclk)
	begin
		if (period == 16'h0000 || (!reset_out_n && !rude))
			cnt_ff <= 16'h0000;
		else if (cnt_ff + 16'h0001 >= period)
		begin
			cnt_ff    <= 16'h0000;
			toggle_ff <= !toggle_ff;
		end
		else
			cnt_ff <= cnt_ff + 16'h0001;
	end
endmodule

// ### tb/swdeh_top_test.sv
// swdeh_top_test: directed tests of the supervisor block
// assumes shortened counts: timeout 200, hold 50 cycles
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module swdeh_top_test;
	localparam int TMO  = 200;
	localparam int HOLD = 50;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        turn_on = 1'b0;
	logic        keep_n = 1'b1;
	logic        mon = 1'b1;
	logic        below = 1'b0;
	logic [1:0]  rp = 2'h1;
	logic        sel0 = 1'b0;
	logic        sel1 = 1'b0;
	logic        wpp = 1'b1;
	logic [15:0] period = 16'h0028;
	logic        rude = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready, pslverr, tog, rst_n, fail_n, on, shdn, err;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;
	always #12.5 pclk = !pclk;
	swdeh_top #(.TMO_CYC(32'h0000_00C8), .HOLD_CYC(32'h0000_0032), .WINDOWED(1)) u_swdeh_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.watchdog_toggle_input(tog), .turn_on_input_one(turn_on), .keep_on_input_n(keep_n),
		.supply_monitor_input(mon), .output_below_threshold(below), .reset_period_pin(rp),
		.watchdog_period_pin(wpp), .watchdog_disable_input_n(1'b1),
		.window_select_bit_zero(sel0), .window_select_bit_one(sel1), .reset_out_n(rst_n),
		.supply_fail_output_n(fail_n), .regulated_output_one(on), .shutdown_mode(shdn));
	swdeh_host u_swdeh_host (.pclk(pclk), .reset_out_n(rst_n), .period(period),
		.rude(rude), .toggle_ff(tog));
	task stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic wait_rst(input logic v, output int k);
		k = 0;
		while (rst_n !== v && k < 5000)
		begin
			@(posedge pclk);
			k++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial
	begin
		tick(2);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0000_0000);
		`CHK("hold", 32'h0000_0032, rd)
		apb(1'b1, 12'h000, 32'h0000_0020);
		apb(1'b0, 12'h000, 32'h0000_0000);
		`CHK("hold wr", 32'h0000_0020, rd)
		apb(1'b0, 12'h004, 32'h0000_0000);
		`CHK("tmo", 32'h0000_00C8, rd)
		apb(1'b1, 12'h004, 32'h0000_0064);
		apb(1'b1, 12'h004, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		`CHK("tmo wr", 32'h0000_0064, rd)
		apb(1'b0, 12'h00C, 32'h0000_0000);
		`CHK("unmapped", 1'b1, err)
		$display("registers done");
		wait_rst(1'b1, n);
		tick(600);
		`CHK("serviced", 1'b1, rst_n)
		period <= 16'h0000;
		wait_rst(1'b0, n);
		rude <= 1'b1;
		period <= 16'h0005;
		tick(20);
		period <= 16'h0000;
		rude <= 1'b0;
		wait_rst(1'b1, n);
		`CHK("hold len", 1'b1, n + 20 >= HOLD && n + 20 <= HOLD + 4)
		wait_rst(1'b0, n);
		`CHK("tmo len", 1'b1, n >= TMO && n <= TMO + 8)
		wpp <= 1'b0;
		wait_rst(1'b1, n);
		wait_rst(1'b0, n);
		`CHK("tmo soft", 1'b1, n >= 100 && n <= 108)
		wpp <= 1'b1;
		wait_rst(1'b1, n);
		period <= 16'h000A;
		wait_rst(1'b0, n);
		`CHK("fast", 1'b1, n < 40)
		apb(1'b0, 12'h008, 32'h0000_0000);
		`CHK("fast flag", 1'b1, rd[5])
		`CHK("slow flag", 1'b1, rd[4])
		`CHK("stat rst", 1'b1, rd[0])
		apb(1'b1, 12'h008, 32'h0000_0020);
		apb(1'b0, 12'h008, 32'h0000_0000);
		`CHK("fast clear", 1'b0, rd[5])
		period <= 16'h0000;
		sel0 <= 1'b1;
		wait_rst(1'b1, n);
		tick(500);
		`CHK("wd off", 1'b1, rst_n)
		sel1 <= 1'b1;
		period <= 16'h000A;
		tick(300);
		`CHK("ratio 64", 1'b1, rst_n)
		period <= 16'h0028;
		tick(50);
		sel0 <= 1'b0;
		sel1 <= 1'b0;
		$display("watchdog done");
		turn_on <= 1'b1;
		tick(5);
		`CHK("turn on", 1'b1, on)
		keep_n <= 1'b0;
		turn_on <= 1'b0;
		tick(5);
		`CHK("kept on", 1'b1, on)
		keep_n <= 1'b1;
		tick(5);
		`CHK("released", 1'b0, on)
		`CHK("shutdown", 1'b1, shdn)
		$display("keep-on done");
		mon <= 1'b0;
		tick(1395);
		`CHK("pf early", 1'b1, fail_n)
		tick(15);
		`CHK("pf low", 1'b0, fail_n)
		mon <= 1'b1;
		$display("supply fail done");
		below <= 1'b1;
		tick(100);
		`CHK("below", 1'b0, rst_n)
		below <= 1'b0;
		wait_rst(1'b1, n);
		`CHK("below hold", 1'b1, n >= HOLD)
		rp <= 2'h2;
		tick(300);
		`CHK("forced", 1'b0, rst_n)
		rp <= 2'h1;
		$display("reset sources done");
		stop_test();
	end
endmodule
